/* File: core/kms_scanner.sv */
// Keypad matrix scanner: column driver, row return sampling, keyboard interrupt and wake
// What this block does
// - An eight-line column bus strobes each column of the key matrix in turn.
// - Any one column can be driven high while all other columns float.
// - All columns can also be driven low, driven high, or floated together.
// - The keyboard interrupt is the OR of the enabled row bits that are inputs.
// - An asserted keyboard interrupt also raises a wake request for standby or idle.
// - An 8x8 matrix is scanned with no outside logic; larger ones need glue.
`timescale 1ns/100ps
module kms_scanner
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [3:0] col_mode_i,
   input wire logic [7:0] row_en_i,
   input wire logic [7:0] row_dir_out_i,
   input wire logic [7:0] row_pin_i,
   output logic [7:0] col_o,
   output logic [7:0] col_oe_o,
   output logic [3:0] col_mode_o,
   output logic [7:0] row_data_o,
   output logic kbd_irq_o,
   output logic wake_o
);
   kms_pkg::kms_mode_t mode_r;
   logic [7:0] row_sync;
   logic [7:0] col_nxt;
   logic [7:0] col_oe_nxt;
   logic irq_nxt;
   logic [7:0] row_live;
   kms_pkg::kms_mode_t mode_nxt;

   // ****************************************
   // Functions
   // ****************************************
   // One-hot select of a single column
   function automatic logic [7:0] kms_onehot(input logic [2:0] idx);
      logic [7:0] sel;
      sel = kms_pkg::ALL_ZERO;
      sel[idx] = 1'b1;
      kms_onehot = sel;
   endfunction : kms_onehot

   // ****************************************
   // Checks and masks
   // ****************************************
   // Codes above the all-float state are not defined
   function automatic logic kms_mode_ok(input logic [3:0] code);
      kms_mode_ok = (code <= kms_pkg::KMS_ALL_HIZ);
   endfunction : kms_mode_ok

   // Row bits that may raise the keyboard interrupt
   // Rows turned to outputs read back our own drive, so they are masked
   function automatic logic [7:0] kms_row_mask
   (
      input logic [7:0] rows,
      input logic [7:0] en,
      input logic [7:0] dir_out
   );
      kms_row_mask = rows & en & ~dir_out;
   endfunction : kms_row_mask

   // ****************************************
   // Row synchroniser
   // ****************************************
   kms_sync u_sync
   (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .async_i(row_pin_i),
      .sync_o(row_sync)
   );

   // ****************************************
   // Mode register
   // ****************************************
   // mode control field
   // Unused codes are refused so the pins never see an undefined drive
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         mode_r <= kms_pkg::kms_mode_t'(kms_pkg::MODE_RST);
      else
         mode_r <= mode_nxt;
   end

   // ****************************************
   // Mode next value
   // ****************************************
   // refused codes hold
   always_comb
   begin
      mode_nxt = mode_r;
      if (kms_mode_ok(col_mode_i))
         mode_nxt = kms_pkg::kms_mode_t'(col_mode_i);
   end

   // ****************************************
   // Column drive decode
   // ****************************************
   always_comb
   begin
      col_nxt = kms_pkg::ALL_ZERO;
      col_oe_nxt = kms_pkg::ALL_ZERO;
      case (mode_r)
         kms_pkg::KMS_ALL_LOW:
         begin
            col_nxt = kms_pkg::ALL_ZERO;
            col_oe_nxt = kms_pkg::ALL_ONES;
         end
         kms_pkg::KMS_ALL_HIGH:
         begin
            col_nxt = kms_pkg::ALL_ONES;
            col_oe_nxt = kms_pkg::ALL_ONES;
         end
         kms_pkg::KMS_ALL_HIZ:
         begin
            col_nxt = kms_pkg::ALL_ZERO;
            col_oe_nxt = kms_pkg::ALL_ZERO;
         end
         // single column high
         // The enable carries the same one-hot so every other column floats
         kms_pkg::KMS_COL0,
         kms_pkg::KMS_COL1,
         kms_pkg::KMS_COL2,
         kms_pkg::KMS_COL3,
         kms_pkg::KMS_COL4,
         kms_pkg::KMS_COL5,
         kms_pkg::KMS_COL6,
         kms_pkg::KMS_COL7:
         begin
            col_nxt = kms_onehot(mode_r[2:0]);
            col_oe_nxt = kms_onehot(mode_r[2:0]);
         end
         // Not reachable; floating is the safe state for the pins
         default:
         begin
            col_nxt = kms_pkg::ALL_ZERO;
            col_oe_nxt = kms_pkg::ALL_ZERO;
         end
      endcase
   end

   // ****************************************
   // Column outputs
   // ****************************************
   // Drive and enable load on the same edge so no column glitches between them
   // registered column strobe
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         col_o <= kms_pkg::ALL_ZERO;
      else
         col_o <= col_nxt;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         col_oe_o <= kms_pkg::ALL_ZERO;
      else
         col_oe_o <= col_oe_nxt;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         col_mode_o <= kms_pkg::MODE_RST;
      else
         col_mode_o <= mode_r;
   end

   // ****************************************
   // Row data and interrupt
   // ****************************************
   // OR of enabled input rows
   // Enables and direction act on the last stage only, so a change there shows in one clock
   assign row_live = kms_row_mask(row_sync, row_en_i, row_dir_out_i);
   assign irq_nxt = |row_live;

   // ****************************************
   // Registered row outputs
   // ****************************************
   // Filtered rows as seen by software
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         row_data_o <= kms_pkg::ALL_ZERO;
      else
         row_data_o <= row_sync;
   end

   // Level interrupt: clears itself when the key is released
   // No latch here; a short press can be missed if software polls slowly
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         kbd_irq_o <= 1'b0;
      else
         kbd_irq_o <= irq_nxt;
   end

   // ****************************************
   // Wake request
   // ****************************************
   // wake from standby or idle
   // Taken from the same term as the interrupt so both rise on one edge
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         wake_o <= 1'b0;
      else
         wake_o <= irq_nxt;
   end
endmodule : kms_scanner

/* File: pkg/kms_pkg.sv */
// Package: constants and types of the keypad matrix scanner
package kms_pkg;
   // ****************************************
   // Widths
   // ****************************************
   localparam int COL_W = 8;
   localparam int ROW_W = 8;
   localparam int MODE_W = 4;

   // ****************************************
   // Column drive modes
   // ****************************************
   // Codes 0..7 select a single column, 8..10 the global states
   typedef enum logic [3:0] {
      KMS_COL0 = 4'h0,
      KMS_COL1 = 4'h1,
      KMS_COL2 = 4'h2,
      KMS_COL3 = 4'h3,
      KMS_COL4 = 4'h4,
      KMS_COL5 = 4'h5,
      KMS_COL6 = 4'h6,
      KMS_COL7 = 4'h7,
      KMS_ALL_LOW = 4'h8,
      KMS_ALL_HIGH = 4'h9,
      KMS_ALL_HIZ = 4'hA
   } kms_mode_t;

   localparam logic [3:0] MODE_RST = 4'hA;
   localparam logic [7:0] ROW_EN_RST = 8'hFF;
   localparam logic [7:0] ROW_DIR_RST = 8'h00;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] ALL_ZERO = 8'h00;
endpackage : kms_pkg

/* File: core/kms_sync.sv */
// Three-stage input synchroniser with agreement filter for the row lines
`timescale 1ns/100ps
module kms_sync
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] async_i,
   output logic [7:0] sync_o
);
   logic [7:0] s1_r;
   logic [7:0] s2_r;
   logic [7:0] s3_r;

   // ****************************************
   // Shift chain
   // ****************************************
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s1_r <= kms_pkg::ALL_ZERO;
         s2_r <= kms_pkg::ALL_ZERO;
         s3_r <= kms_pkg::ALL_ZERO;
      end
      else
      begin
         s1_r <= async_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // ****************************************
   // Agreement
   // ****************************************
   // A bit changes only when stages two and three agree
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         sync_o <= kms_pkg::ALL_ZERO;
      else
         sync_o <= (s2_r & s3_r) | (sync_o & (s2_r ^ s3_r));
   end
endmodule : kms_sync

/* File: verification/kms_scanner_assertions.sv */
// Checker of the keypad scanner ports
`timescale 1ns/100ps
module kms_scanner_assertions
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [3:0] col_mode_i,
   input wire logic [7:0] row_en_i,
   input wire logic [7:0] row_dir_out_i,
   input wire logic [7:0] row_pin_i,
   input wire logic [7:0] col_o,
   input wire logic [7:0] col_oe_o,
   input wire logic [3:0] col_mode_o,
   input wire logic [7:0] row_data_o,
   input wire logic kbd_irq_o,
   input wire logic wake_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   property p_mode; col_mode_i <= 4'hA |-> ##2 col_mode_o == $past(col_mode_i, 2); endproperty
   a_mode: assert property (p_mode) else $error("mode lost");
   property p_strobe; col_mode_i < 4'h8 |-> ##2 col_o == (8'h01 << $past(col_mode_i, 2)); endproperty
   a_strobe: assert property (p_strobe) else $error("strobe");
   property p_one; col_mode_o < 4'h8 |-> col_oe_o == col_o; endproperty
   a_one: assert property (p_one) else $error("float");
   property p_all; col_mode_o[3] |-> col_oe_o == {8{col_mode_o != 4'hA}}; endproperty
   a_all: assert property (p_all) else $error("global");
   // Rows must be steady past the filter depth
   property p_rows; $stable(row_pin_i) [*6] |-> row_data_o == row_pin_i; endproperty
   a_rows: assert property (p_rows) else $error("rows");
   property p_irq; kbd_irq_o == |(row_data_o & $past(row_en_i) & ~$past(row_dir_out_i)); endproperty
   a_irq: assert property (p_irq) else $error("irq");
   property p_wake; wake_o == kbd_irq_o; endproperty
   a_wake: assert property (p_wake) else $error("wake");
   property p_drive; col_mode_o[3] |-> col_o == {8{col_mode_o == 4'h9}}; endproperty
   a_drive: assert property (p_drive) else $error("drive level");
   cover property (col_mode_i > 4'hA);
   cover property (col_mode_o == 4'h7);
   cover property ($rose(kbd_irq_o));
   cover property (col_mode_o == 4'h9);
endmodule : kms_scanner_assertions

/* File: verification/kms_key_matrix.sv */
// Key matrix model, rows pulled low
`timescale 1ns/100ps
module kms_key_matrix
(
   input wire logic [7:0] col_i,
   input wire logic [7:0] col_oe_i,
   input wire logic [63:0] keys_i,
   output logic [7:0] row_o
);
   always_comb
   begin
      row_o = 8'h00;
      for (int c = 0; c < 8; c++)
         row_o = row_o | (keys_i[c*8 +: 8] & {8{col_oe_i[c] & col_i[c]}});
   end
endmodule : kms_key_matrix

/* File: verification/tb.sv */
// Bench: scanner against key matrix and reference model
`timescale 1ns/100ps
module tb;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] md = 4'hA, col_mode, em;
   logic [7:0] en = 8'h00, dir = 8'h00, pin, col, oe, rd, eoe, erow;
   logic [63:0] keys = 64'h0;
   logic irq, wake;
   int n_fail = 0;
   int comparisons = 0;
   int mode_q[$];
   kms_scanner dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .col_mode_i(md), .row_en_i(en), .row_dir_out_i(dir),
      .row_pin_i(pin), .col_o(col), .col_oe_o(oe), .col_mode_o(col_mode), .row_data_o(rd), .kbd_irq_o(irq),
      .wake_o(wake));
   kms_key_matrix mtx (.col_i(col), .col_oe_i(oe), .keys_i(keys), .row_o(pin));
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : chk
   task automatic complete_run();
      if (n_fail == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   // Rows seen when driven-high columns close keys, others pulled low
   function automatic logic [7:0] exp_rows(input logic [63:0] k, input logic [3:0] m);
      int c;
      exp_rows = 8'h00;
      for (c = 0; c < 8; c++)
         if ((m == 4'h9) || (m == 4'(c)))
            exp_rows = exp_rows | k[c*8 +: 8];
   endfunction : exp_rows
   task automatic step(input logic [3:0] code);
      md = code;
      keys = {$urandom, $urandom};
      en = 8'($urandom);
      dir = 8'($urandom);
      if (code <= 4'hA)
         mode_q.push_back(int'(code));
      em = 4'(mode_q[$]);
      eoe = (em < 4'h8) ? 8'h01 << em : {8{em != 4'hA}};
      erow = exp_rows(keys, em);
      repeat (8) @(negedge sys_clk_i);
      chk({col_mode, oe, col & oe}, {em, eoe, eoe & {8{em != 4'h8}}});
      chk({pin, rd}, {erow, erow});
      chk({irq, wake}, {2{|(erow & en & ~dir)}});
   endtask : step
   initial
      forever #2.5 sys_clk_i = ~sys_clk_i;
   initial
   begin
      #20000;
      n_fail++;
      complete_run();
   end
   initial
   begin
      void'($urandom(32'hE079));
      mode_q.push_back(32'hA);
      repeat (5) @(negedge sys_clk_i);
      rst_i = 1'b0;
      chk({oe, col_mode}, 12'h00A);
      // Codes 0..10 once a round plus two random refused codes; each refused code follows a single column
      for (int k = 0; k < 130; k++)
         step(((k * 7) % 13 < 11) ? 4'((k * 7) % 13) : 4'(11 + $urandom % 5));
      // Reset in mid-run with a column driven
      rst_i = 1'b1;
      @(negedge sys_clk_i);
      chk({col, oe, col_mode, rd, irq, wake}, {16'h0000, 4'hA, 8'h00, 2'h0});
      mode_q.push_back(32'hA);
      rst_i = 1'b0;
      step(4'hB);
      step(4'h9);
      complete_run();
   end
endmodule : tb
bind kms_scanner kms_scanner_assertions chk_u (.*);
